// >>> ashp_pkg.sv
// Package of constants and types for the converter serial host port.
package ashp_pkg;
  localparam int CFG_WIDTH = 24;
  localparam logic [23:0] CFG_RESET = 24'h000000;
  localparam logic [23:0] CAL_RESET = 24'h000000;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CAL_RW = 3'h6;
  localparam int MODE_MSB = 23;
  localparam int MODE_LSB = 21;
  localparam int BIPOLAR_BIT = 0;
  localparam int SELF_CLK_DIV = 4;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic        bipolar;
    logic [23:0] value;
  } ashp_result_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_WRITE = 2'h1,
    ST_READ  = 2'h2
  } ashp_state_t;
endpackage

// >>> ashp_fifo.sv
// Result buffer FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ashp_fifo
  import ashp_pkg::*;
#(
  parameter int WIDTH = 25,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_depth_check
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  assign in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_r != rd_r;
  assign out_data  = mem[rd_r[AW-1:0]];
  always_ff @(posedge sys_clk)
  begin
    if (in_valid && in_ready)
      mem[wr_r[AW-1:0]] <= in_data;
  end
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wr_r <= wr_r + 1'b1;
      if (out_valid && out_ready)
        rd_r <= rd_r + 1'b1;
    end
  end
endmodule // ashp_fifo

// >>> ashp_port.sv
// Serial host port top level: framing, shifter, registers and result ready flag.
`timescale 1ns/1ps
module ashp_port
  import ashp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         self_clock_mode,
  input  wire logic         write_frame_n,
  input  wire logic         read_frame_n,
  input  wire logic         register_select,
  input  wire logic         serial_clk_in,
  output logic              serial_clk_out,
  output logic              serial_clk_oe,
  input  wire logic         serial_io_line_in,
  output logic              serial_io_line_out,
  output logic              serial_io_line_oe,
  output logic              result_ready_n,
  input  wire logic [23:0]  conv_data,
  input  wire logic         conv_valid,
  output logic              conv_ready,
  input  wire logic         cal_done,
  output logic [23:0]       config_word,
  output logic [23:0]       cal_coeff
);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_depth_check
    $error("DEPTH must be a power of two of at least 2");
  end
  if (CFG_WIDTH != 24)
  begin : g_width_check
    $error("The shifter serves a 24-bit word only");
  end
  if (SELF_CLK_DIV < 1 || SELF_CLK_DIV > 256)
  begin : g_div_check
    $error("SELF_CLK_DIV does not fit the divider");
  end


  // ==========================================================
  // Input synchronisers
  logic [1:0] wf_s;
  logic [1:0] rf_s;
  logic [1:0] sel_s;
  logic [1:0] sck_s;
  logic [1:0] sdi_s;
  logic       sck_d_r;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wf_s    <= 2'h3;
      rf_s    <= 2'h3;
      sel_s   <= 2'h0;
      sck_s   <= 2'h0;
      sdi_s   <= 2'h0;
      sck_d_r <= 1'b0;
    end
    else
    begin
      wf_s    <= {wf_s[0], write_frame_n};
      rf_s    <= {rf_s[0], read_frame_n};
      sel_s   <= {sel_s[0], register_select};
      sck_s   <= {sck_s[0], serial_clk_in};
      sdi_s   <= {sdi_s[0], serial_io_line_in};
      sck_d_r <= sck_s[1];
    end
  end
  wire wf_low = !wf_s[1];
  wire rf_low = !rf_s[1];
  wire sel    = sel_s[1];

  // ==========================================================
  // Self clock generator
  logic [7:0] div_r;
  logic       sclk_r;
  ashp_state_t state_r;
  wire self_on = self_clock_mode && (state_r != ST_IDLE);
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_r  <= 8'h00;
      sclk_r <= 1'b0;
    end
    else if (!self_on)
    begin
      div_r  <= 8'h00;
      sclk_r <= 1'b0;
    end
    else if (div_r == 8'(SELF_CLK_DIV - 1))
    begin
      div_r  <= 8'h00;
      sclk_r <= !sclk_r;
    end
    else
      div_r <= div_r + 8'h01;
  end
  wire self_tick = self_on && (div_r == 8'(SELF_CLK_DIV - 1));
  wire self_rise = self_tick && !sclk_r;
  wire self_fall = self_tick && sclk_r;
  // The external clock is judged on its synchronised copy, so its edges show up two cycles late.
  wire ext_rise  = sck_s[1] && !sck_d_r;
  wire ext_fall  = !sck_s[1] && sck_d_r;
  wire rise = self_clock_mode ? self_rise : ext_rise;
  wire fall = self_clock_mode ? self_fall : ext_fall;

  // ==========================================================
  // Result buffer
  ashp_result_t   fifo_out;
  logic           fifo_valid;
  logic           fifo_pop;
  ashp_result_t   fifo_in;
  assign fifo_in.bipolar = config_word[BIPOLAR_BIT];
  assign fifo_in.value   = conv_data;
  ashp_fifo #(.WIDTH(25), .DEPTH(DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_data   (fifo_in),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );
  // Offset binary flips the sign bit of a two's complement sample.
  function automatic logic [23:0] encode(input ashp_result_t r);
    encode = r.bipolar ? {~r.value[23], r.value[22:0]} : r.value;
  endfunction

  // ==========================================================
  // Frame state machine and shifter
  logic [23:0] shift_r;
  logic [4:0]  cnt_r;
  logic        src_result_r;
  logic        cal_flag_r;
  logic        sdo_r;
  logic [23:0] load_word;
  wire [2:0] mode        = config_word[MODE_MSB:MODE_LSB];
  wire       result_read = sel && (mode == MODE_NORMAL);
  wire       ready_now   = fifo_valid || cal_flag_r;
  wire       word_full   = cnt_r == 5'(CFG_WIDTH);
  wire       read_start  = (state_r == ST_IDLE) && !wf_low && rf_low && (!result_read || ready_now);
  wire       wr_shift    = (state_r == ST_WRITE) && wf_low && rise && !word_full;
  wire       rd_shift    = (state_r == ST_READ) && rf_low && fall && !word_full;

  // The first bit stands on the line from frame start, before any falling edge.
  always_comb
  begin
    if (!sel)
      load_word = config_word;
    else if (result_read)
      load_word = fifo_valid ? encode(fifo_out) : 24'h000000;
    else
      load_word = cal_coeff;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (wf_low)
            state_r <= ST_WRITE;
          else if (read_start)
            state_r <= ST_READ;
        end
        ST_WRITE:
        begin
          if (!wf_low)
            state_r <= ST_IDLE;
        end
        ST_READ:
        begin
          if (!rf_low)
            state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // The counter stops at the word length, so pulses past it fall away.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_r <= 5'h00;
    else if (state_r == ST_IDLE)
      cnt_r <= 5'h00;
    else if (wr_shift || rd_shift)
      cnt_r <= cnt_r + 5'h01;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      shift_r <= 24'h000000;
    else if (read_start)
      shift_r <= load_word;
    else if (wr_shift)
      shift_r <= {shift_r[22:0], sdi_s[1]};
    else if (rd_shift)
      shift_r <= {shift_r[22:0], 1'b0};
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      src_result_r <= 1'b0;
    else if (read_start)
      src_result_r <= result_read;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      sdo_r <= 1'b0;
    else if (read_start)
      sdo_r <= load_word[23];
    else if (rd_shift)
      sdo_r <= shift_r[22];
  end
  wire write_done = (state_r == ST_WRITE) && !wf_low && word_full;
  wire read_done  = rd_shift && (cnt_r == 5'(CFG_WIDTH - 1));

  // ==========================================================
  // Registers
  // A write commits only when the strobe rises with a full word, so a cut frame changes nothing.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      config_word <= CFG_RESET;
      cal_coeff   <= CAL_RESET;
    end
    else if (write_done)
    begin
      if (!sel)
        config_word <= shift_r;
      else if (mode == MODE_CAL_RW)
        cal_coeff <= shift_r;
    end
  end

  // ==========================================================
  // Result ready flag
  assign fifo_pop = read_done && src_result_r && fifo_valid;
  // Calibration completion is held until a result word is read, so it is never missed.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cal_flag_r <= 1'b0;
    else if (cal_done)
      cal_flag_r <= 1'b1;
    else if (read_done && src_result_r)
      cal_flag_r <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      result_ready_n <= 1'b1;
    else if (read_done && src_result_r)
      result_ready_n <= 1'b1;
    else if (state_r == ST_IDLE && ready_now)
      result_ready_n <= 1'b0;
  end

  // ==========================================================
  // Pin drivers
  // The line is let go as soon as the synchronised read strobe rises.
  assign serial_clk_out     = sclk_r;
  assign serial_clk_oe      = self_on;
  assign serial_io_line_out = sdo_r;
  assign serial_io_line_oe  = (state_r == ST_READ) && rf_low;
endmodule // ashp_port

// >>> ashp_port_properties.sv
// Concurrent checks on the serial host port pins.
`timescale 1ns/1ps
module ashp_port_properties
  import ashp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        write_frame_n,
  input wire logic        read_frame_n,
  input wire logic        register_select,
  input wire logic        serial_clk_out,
  input wire logic        serial_clk_oe,
  input wire logic        serial_io_line_oe,
  input wire logic        result_ready_n,
  input wire logic        conv_valid,
  input wire logic        conv_ready,
  input wire logic        cal_done,
  input wire logic [23:0] config_word
);
  // ==========
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_clk_fr;
    $rose(serial_clk_oe) |-> !write_frame_n || !read_frame_n;
  endproperty
  a_clk_fr: assert property (p_clk_fr) else $error("clock out of frame");
  property p_clk_idle;
    !serial_clk_oe && !$past(serial_clk_oe) |-> !serial_clk_out;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clock runs outside frame");
  property p_rd_on;
    $rose(serial_io_line_oe) |-> !read_frame_n;
  endproperty
  a_rd_on: assert property (p_rd_on) else $error("drive without strobe");
  property p_rd_off;
    $rose(read_frame_n) |-> ##[0:4] !serial_io_line_oe;
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("drive after strobe");
  property p_rdy_fall;
    conv_valid && conv_ready && read_frame_n |-> ##[1:3] !result_ready_n;
  endproperty
  a_rdy_fall: assert property (p_rdy_fall) else $error("ready flag late");
  property p_rdy_rise;
    $rose(result_ready_n) |-> !read_frame_n;
  endproperty
  a_rdy_rise: assert property (p_rdy_rise) else $error("ready flag rose idle");
  property p_cal;
    cal_done |-> ##[1:2] !result_ready_n;
  endproperty
  a_cal: assert property (p_cal) else $error("cal flag missing");
  property p_res_rdy;
    $rose(serial_io_line_oe) && register_select &&
      (config_word[MODE_MSB:MODE_LSB] == MODE_NORMAL) |-> !result_ready_n;
  endproperty
  a_res_rdy: assert property (p_res_rdy) else $error("result read unready");
  property p_no_clash;
    serial_io_line_oe |-> write_frame_n;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("drive in write");
  property p_cfg_upd;
    $changed(config_word) |-> !register_select && write_frame_n;
  endproperty
  a_cfg_upd: assert property (p_cfg_upd) else $error("config load wrong");
endmodule // ashp_port_properties

// >>> ashp_host_model.sv
// Host serial port model with external clock.
`timescale 1ns/1ps
module ashp_host_model
  import ashp_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic line_oe,
  input  wire logic line_out,
  output logic      write_frame_n,
  output logic      read_frame_n,
  output logic      host_clk,
  output logic      line_in
);
  // ==========
  // Line and frames
  logic drv;
  logic bit_v;
  // A released line shows the inverse of its last level, so stale data cannot pass.
  assign line_in = line_oe ? line_out : (drv ? bit_v : ~bit_v);
  initial
  begin
    write_frame_n = 1'b1;
    read_frame_n = 1'b1;
    host_clk = 1'b0;
    drv = 1'b0;
    bit_v = 1'b0;
  end
  task automatic xfer(input logic wr, input int n, input logic [31:0] d, output logic [23:0] q);
    q = 24'h0;
    @(posedge sys_clk);
    if (wr)
      write_frame_n <= 1'b0;
    else
      read_frame_n <= 1'b0;
    drv <= wr;
    repeat (8) @(posedge sys_clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      bit_v <= d[i];
      repeat (4) @(posedge sys_clk);
      host_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      q = {q[22:0], line_in};
      host_clk <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    write_frame_n <= 1'b1;
    read_frame_n <= 1'b1;
    drv <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule // ashp_host_model

// >>> tb_ashp_port.sv
// Bench for the converter serial host port.
`timescale 1ns/1ps
module tb_ashp_port;
  import ashp_pkg::*;
  // ==========
  // Signals and instances
  logic        sys_clk = 1'b0;
  logic        rst_b, self_clock_mode, register_select, conv_valid, cal_done;
  logic        write_frame_n, read_frame_n, host_clk, line_in;
  logic        serial_clk_out, serial_clk_oe, serial_io_line_out, serial_io_line_oe, result_ready_n, conv_ready;
  logic [23:0] conv_data, q, config_word, cal_coeff;
  int          mismatches = 0;
  int          n_compared = 0;
  wire         clk_pin = serial_clk_oe ? serial_clk_out : host_clk;
  always #50 sys_clk = ~sys_clk;
  ashp_port u_ashp_port (
    .sys_clk            (sys_clk),
    .rst_b              (rst_b),
    .self_clock_mode    (self_clock_mode),
    .write_frame_n      (write_frame_n),
    .read_frame_n       (read_frame_n),
    .register_select    (register_select),
    .serial_clk_in      (clk_pin),
    .serial_clk_out     (serial_clk_out),
    .serial_clk_oe      (serial_clk_oe),
    .serial_io_line_in  (line_in),
    .serial_io_line_out (serial_io_line_out),
    .serial_io_line_oe  (serial_io_line_oe),
    .result_ready_n     (result_ready_n),
    .conv_data          (conv_data),
    .conv_valid         (conv_valid),
    .conv_ready         (conv_ready),
    .cal_done           (cal_done),
    .config_word        (config_word),
    .cal_coeff          (cal_coeff)
  );
  ashp_host_model u_ashp_host_model (.sys_clk, .line_oe(serial_io_line_oe), .line_out(serial_io_line_out),
    .write_frame_n, .read_frame_n, .host_clk, .line_in);
  // ==========
  // Tasks
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input int n, input logic [31:0] d);
    u_ashp_host_model.xfer(1'b1, n, d, q);
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic rd;
    u_ashp_host_model.xfer(1'b0, 24, 32'h0, q);
  endtask
  task automatic push(input logic [23:0] v);
    @(posedge sys_clk);
    conv_data <= v;
    conv_valid <= 1'b1;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // Tests
  initial
  begin
    rst_b = 1'b0;
    self_clock_mode = 1'b0;
    register_select = 1'b0;
    conv_valid = 1'b0;
    cal_done = 1'b0;
    conv_data = 24'h0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(config_word, CFG_RESET);
    chk(24'(result_ready_n), 24'h1);
    wr(24, 32'h001a5a5a);
    chk(config_word, 24'h1a5a5a);
    wr(12, 32'h00000f0f);
    chk(config_word, 24'h1a5a5a);
    wr(30, 32'h030f0f2a);
    chk(config_word, 24'h0c3c3c);
    rd();
    chk(q, 24'h0c3c3c);
    // One push past the depth shows the refusal when the buffer is full.
    for (int i = 0; i < 17; i++)
      push(24'h800000 + 24'(i));
    chk(24'(conv_ready), 24'h0);
    chk(24'(result_ready_n), 24'h0);
    register_select <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      rd();
      chk(q, 24'h800000 + 24'(i));
    end
    chk(24'(result_ready_n), 24'h1);
    register_select <= 1'b0;
    wr(24, 32'h00000001);
    push(24'h800005);
    register_select <= 1'b1;
    rd();
    chk(q, 24'h000005);
    register_select <= 1'b0;
    self_clock_mode <= 1'b1;
    wr(24, 32'h0);
    chk(config_word, 24'h000000);
    self_clock_mode <= 1'b0;
    wr(24, 32'h00c00000);
    chk(config_word, 24'hc00000);
    register_select <= 1'b1;
    wr(24, 32'h005a3c96);
    chk(cal_coeff, 24'h5a3c96);
    rd();
    chk(q, 24'h5a3c96);
    register_select <= 1'b0;
    wr(24, 32'h00000000);
    chk(config_word, 24'h000000);
    cal_done <= 1'b1;
    @(posedge sys_clk);
    cal_done <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(24'(result_ready_n), 24'h0);
    conclude();
  end
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
endmodule // tb_ashp_port
bind ashp_port ashp_port_properties #(.DEPTH(DEPTH)) u_ashp_port_properties (
  .sys_clk           (sys_clk),
  .rst_b             (rst_b),
  .write_frame_n     (write_frame_n),
  .read_frame_n      (read_frame_n),
  .register_select   (register_select),
  .serial_clk_out    (serial_clk_out),
  .serial_clk_oe     (serial_clk_oe),
  .serial_io_line_oe (serial_io_line_oe),
  .result_ready_n    (result_ready_n),
  .conv_valid        (conv_valid),
  .conv_ready        (conv_ready),
  .cal_done          (cal_done),
  .config_word       (config_word)
);
